// ==== hdl/ifr_fault_pin.sv ====
/*
  Fault pin driver: masks the primary fault sources and drives the active-low
  pin either live or sticky. Assumes synchronous inputs from the register bank.
*/
`timescale 1ns/1ps
module ifr_fault_pin
  import ifr_pkg::*;
(
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst,
  // configuration
  input  wire logic       sticky_select,
  input  wire logic [7:0] pin_mask,
  // sources
  input  wire logic [7:0] live_sources,
  input  wire logic [7:0] latched_sources,
  input  wire logic       primary_read,
  // pin
  output logic            fault_n_q
);
  logic hold_q;
  logic latched_hit;
  logic live_hit;

  // ----------------------------------------------------------------------
  // masking
  // ----------------------------------------------------------------------
  assign latched_hit = |(latched_sources & pin_mask);
  assign live_hit    = |(live_sources & pin_mask);

  // sticky hold; the read clears it even though the latched bits are still
  // set in that cycle, otherwise the pin could never be released. a source
  // that is still live in the read cycle is relatched by the bank, so the
  // pin stays low through the latched bits and no fault is lost
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      hold_q <= 1'b0;
    end else if (primary_read) begin
      hold_q <= 1'b0;
    end else if (latched_hit) begin
      hold_q <= 1'b1;
    end
  end

  // pin is driven low for a fault
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      fault_n_q <= 1'b1;
    end else if (sticky_select) begin
      fault_n_q <= ~(latched_hit | hold_q);
    end else begin
      fault_n_q <= ~live_hit;
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  a_live_pin_follow: assert property (!sticky_select |=> fault_n_q == !$past(live_hit))
    else $error("live fault pin does not follow masked sources");
  a_sticky_pin_hold: assert property (sticky_select && latched_hit && !primary_read
      ##1 sticky_select && !primary_read |=> !fault_n_q)
    else $error("sticky fault pin released before primary read");
  a_masked_no_fault: assert property (!sticky_select && (live_sources & pin_mask) == BYTE_ZERO
      |=> fault_n_q)
    else $error("fault pin asserted by masked source");
endmodule

// ==== hdl/ifr_pkg.sv ====
/*
  Constants for the input enable and fault reporting register bank: register
  offsets, reset values, bit positions and masks of writable bits.
  Assumes an outer SPI front end that has already framed each command.
*/
// Notes on behaviour
// - a zero enable bit disables that input and forces its state bit low; all enabled at reset
// - a frame whose clock count is not a multiple of eight sets bit 5, is rejected
// - overtemperature sets bit 4 and turns off inputs and LED drivers; SPI stays up
// - current reference open, or thermal shutdown, sets bit 3; inputs untouched
// - current reference short sets bit 2; inputs disabled while the short lasts
// - bit 1 on wire-break reference open, thermal shutdown, or all wire-break off
// - wire-break reference short sets bit 0; inputs untouched
// - reference fault flags stay latched and clear on read of the secondary register
// - an enabled secondary source sets the summary bit of the primary register
// - non-sticky fault pin follows the OR of unmasked live sources
// - sticky fault pin holds asserted until the primary register is read
// - a primary source reaches the fault pin only when its mask bit is 1
// - the fault pin is active low
// - reading the primary register clears the summary only if no enabled source remains
package ifr_pkg;
  // ----------------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------------
  localparam logic [6:0] ADDR_PRIMARY   = 7'h04;
  localparam logic [6:0] ADDR_IN_ENABLE = 7'h1A;
  localparam logic [6:0] ADDR_SEC_STAT  = 7'h1C;
  localparam logic [6:0] ADDR_SEC_EN    = 7'h1E;
  localparam logic [6:0] ADDR_PIN_CFG   = 7'h22;
  localparam logic [6:0] ADDR_PIN_MASK  = 7'h24;

  // ----------------------------------------------------------------------
  // reset values and writable-bit masks
  // ----------------------------------------------------------------------
  localparam logic [7:0] RST_IN_ENABLE  = 8'hFF;
  localparam logic [7:0] RST_SEC_STAT   = 8'h02;
  localparam logic [7:0] RST_SEC_EN     = 8'h00;
  localparam logic [7:0] RST_PIN_CFG    = 8'h00;
  localparam logic [7:0] RST_PIN_MASK   = 8'hC0;
  localparam logic [7:0] RST_PRIMARY    = 8'h46;
  localparam logic [7:0] MASK_SEC       = 8'h3F;
  localparam logic [7:0] MASK_PIN_CFG   = 8'h80;
  localparam logic [7:0] BYTE_ZERO      = 8'h00;
  localparam logic [7:0] BYTE_ONES      = 8'hFF;
  // primary bits cleared by a read when their source is gone
  localparam logic [7:0] PRIM_COR_MASK  = 8'h3E;

  // ----------------------------------------------------------------------
  // bit positions
  // ----------------------------------------------------------------------
  localparam int SEC_CLK_ERR  = 5;
  localparam int SEC_OT_SHDN  = 4;
  localparam int SEC_CREF_OPN = 3;
  localparam int SEC_CREF_SHT = 2;
  localparam int SEC_WREF_OPN = 1;
  localparam int SEC_WREF_SHT = 0;
  localparam int PRIM_CRC     = 7;
  localparam int PRIM_POR     = 6;
  localparam int PRIM_SUMMARY = 5;
  localparam int PRIM_T_HIGH  = 4;
  localparam int PRIM_T_LOW   = 3;
  localparam int PRIM_SUP_LOW = 2;
  localparam int PRIM_SUP_MIS = 1;
  localparam int PRIM_WB_SUM  = 0;
  localparam int CFG_STICKY   = 7;
endpackage

// ==== hdl/ifr_regs.sv ====
/*
  Register bank for input enables and fault reporting of an octal digital
  input device. Assumes an SPI front end that hands over one decoded command
  per frame, with a flag telling whether the clock count was whole bytes.
*/
`timescale 1ns/1ps
module ifr_regs
  import ifr_pkg::*;
(
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst,
  // decoded command from the serial front end
  input  wire logic       cmd_valid,
  input  wire logic       cmd_clk_ok,
  input  wire logic       cmd_write,
  input  wire logic [6:0] cmd_addr,
  input  wire logic [7:0] cmd_wdata,
  output logic            rd_valid_q,
  output logic [7:0]      rd_data_q,
  // analog front end status
  input  wire logic [7:0] raw_inputs,
  input  wire logic [7:0] wb_detect_enable,
  input  wire logic       overtemp,
  input  wire logic       cref_open,
  input  wire logic       cref_short,
  input  wire logic       wref_open,
  input  wire logic       wref_short,
  // primary fault sources
  input  wire logic       crc_error,
  input  wire logic       temp_alarm_low,
  input  wire logic       temp_alarm_high,
  input  wire logic       supply_low,
  input  wire logic       supply_missing,
  input  wire logic       wirebreak_any,
  // channel and pin outputs
  output logic [7:0]      channel_active_q,
  output logic [7:0]      input_state_bits_q,
  output logic            led_drive_on_q,
  output logic            fault_n_q
);
  import ifr_pkg::*;

  logic [7:0] input_channel_enable_q;
  logic [7:0] secondary_fault_status_q;
  logic [7:0] secondary_fault_enable_q;
  logic [7:0] fault_pin_config_q;
  logic [7:0] primary_fault_pin_mask_q;
  logic [7:0] primary_fault_status_q;
  logic [7:0] sec_set;
  logic [7:0] prim_live;
  logic [7:0] rd_mux;
  logic       cmd_ok;
  logic       wr_en;
  logic       rd_en;
  logic       summary_live;

  // ----------------------------------------------------------------------
  // command qualification
  // ----------------------------------------------------------------------
  // a short frame is dropped whole so no register sees half a command
  assign cmd_ok = cmd_valid & cmd_clk_ok;
  assign wr_en  = cmd_ok & cmd_write;
  assign rd_en  = cmd_ok & ~cmd_write;

  // ----------------------------------------------------------------------
  // writable registers
  // ----------------------------------------------------------------------
  // plain read/write registers, reserved bits held at zero
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      input_channel_enable_q   <= RST_IN_ENABLE;
      secondary_fault_enable_q <= RST_SEC_EN;
      fault_pin_config_q       <= RST_PIN_CFG;
      primary_fault_pin_mask_q <= RST_PIN_MASK;
    end else if (wr_en) begin
      unique case (cmd_addr)
        ADDR_IN_ENABLE: input_channel_enable_q   <= cmd_wdata;
        ADDR_SEC_EN:    secondary_fault_enable_q <= cmd_wdata & MASK_SEC;
        ADDR_PIN_CFG:   fault_pin_config_q       <= cmd_wdata & MASK_PIN_CFG;
        ADDR_PIN_MASK:  primary_fault_pin_mask_q <= cmd_wdata;
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // secondary fault status, latched and clear-on-read
  // ----------------------------------------------------------------------
  always_comb begin
    sec_set               = BYTE_ZERO;
    sec_set[SEC_CLK_ERR]  = cmd_valid & ~cmd_clk_ok;
    sec_set[SEC_OT_SHDN]  = overtemp;
    sec_set[SEC_CREF_OPN] = cref_open | overtemp;
    sec_set[SEC_CREF_SHT] = cref_short;
    sec_set[SEC_WREF_OPN] = wref_open | overtemp | (wb_detect_enable == BYTE_ZERO);
    sec_set[SEC_WREF_SHT] = wref_short;
  end

  // a live condition in the read cycle sets again, so no event is lost
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      secondary_fault_status_q <= RST_SEC_STAT;
    end else if (rd_en && cmd_addr == ADDR_SEC_STAT) begin
      secondary_fault_status_q <= sec_set;
    end else begin
      secondary_fault_status_q <= secondary_fault_status_q | sec_set;
    end
  end

  // ----------------------------------------------------------------------
  // primary fault status (only the parts this bank needs)
  // ----------------------------------------------------------------------
  assign summary_live = |(secondary_fault_status_q & secondary_fault_enable_q);

  always_comb begin
    prim_live               = BYTE_ZERO;
    prim_live[PRIM_CRC]     = crc_error;
    prim_live[PRIM_POR]     = primary_fault_status_q[PRIM_POR];
    prim_live[PRIM_SUMMARY] = summary_live;
    prim_live[PRIM_T_HIGH]  = temp_alarm_high;
    prim_live[PRIM_T_LOW]   = temp_alarm_low;
    prim_live[PRIM_SUP_LOW] = supply_low;
    prim_live[PRIM_SUP_MIS] = supply_missing;
    prim_live[PRIM_WB_SUM]  = wirebreak_any;
  end

  // crc and wire-break summary mirror their sources; the power-on flag clears
  // only by writing zero; the rest clear on read unless still present
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      primary_fault_status_q <= RST_PRIMARY;
    end else begin
      primary_fault_status_q[PRIM_CRC]    <= crc_error;
      primary_fault_status_q[PRIM_WB_SUM] <= wirebreak_any;
      if (wr_en && cmd_addr == ADDR_PRIMARY && !cmd_wdata[PRIM_POR]) begin
        primary_fault_status_q[PRIM_POR] <= 1'b0;
      end
      if (rd_en && cmd_addr == ADDR_PRIMARY) begin
        primary_fault_status_q[PRIM_SUMMARY:PRIM_SUP_MIS] <=
          prim_live[PRIM_SUMMARY:PRIM_SUP_MIS];
      end else begin
        primary_fault_status_q[PRIM_SUMMARY:PRIM_SUP_MIS] <=
          primary_fault_status_q[PRIM_SUMMARY:PRIM_SUP_MIS] |
          prim_live[PRIM_SUMMARY:PRIM_SUP_MIS];
      end
    end
  end

  // ----------------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------------
  always_comb begin
    unique case (cmd_addr)
      ADDR_PRIMARY:   rd_mux = primary_fault_status_q;
      ADDR_IN_ENABLE: rd_mux = input_channel_enable_q;
      ADDR_SEC_STAT:  rd_mux = secondary_fault_status_q;
      ADDR_SEC_EN:    rd_mux = secondary_fault_enable_q;
      ADDR_PIN_CFG:   rd_mux = fault_pin_config_q;
      ADDR_PIN_MASK:  rd_mux = primary_fault_pin_mask_q;
      default:        rd_mux = BYTE_ZERO; // unmapped reads as zero
    endcase
  end

  // data is the value before any clear-on-read takes effect
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rd_valid_q <= 1'b0;
      rd_data_q  <= BYTE_ZERO;
    end else begin
      rd_valid_q <= rd_en;
      rd_data_q  <= rd_en ? rd_mux : rd_data_q;
    end
  end

  // ----------------------------------------------------------------------
  // channel gating
  // ----------------------------------------------------------------------
  // live conditions gate, not the latched flags, so inputs return when a
  // fault clears even before software reads the status
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      channel_active_q   <= BYTE_ZERO;
      input_state_bits_q <= BYTE_ZERO;
      led_drive_on_q     <= 1'b0;
    end else begin
      channel_active_q   <= (overtemp | cref_short) ? BYTE_ZERO :
                            input_channel_enable_q;
      input_state_bits_q <= (overtemp | cref_short) ? BYTE_ZERO :
                            raw_inputs & input_channel_enable_q;
      led_drive_on_q     <= ~overtemp;
    end
  end

  // ----------------------------------------------------------------------
  // fault pin
  // ----------------------------------------------------------------------
  ifr_fault_pin u_fault_pin (
    .ref_clk         (ref_clk),
    .rst             (rst),
    .sticky_select   (fault_pin_config_q[CFG_STICKY]),
    .pin_mask        (primary_fault_pin_mask_q),
    .live_sources    (prim_live),
    .latched_sources (primary_fault_status_q),
    .primary_read    (rd_en && cmd_addr == ADDR_PRIMARY),
    .fault_n_q       (fault_n_q)
  );

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence s_bad_frame;
    cmd_valid && !cmd_clk_ok;
  endsequence
  sequence s_sec_read_quiet;
    rd_en && cmd_addr == ADDR_SEC_STAT && sec_set == BYTE_ZERO;
  endsequence

  a_disabled_state_low: assert property (1'b1 |=>
      (input_state_bits_q & ~$past(input_channel_enable_q)) == BYTE_ZERO)
    else $error("disabled channel shows a high state");
  a_bad_frame_flag: assert property (s_bad_frame |=> secondary_fault_status_q[SEC_CLK_ERR])
    else $error("clock count error not flagged");
  a_bad_frame_nowrite: assert property (s_bad_frame |=> $stable(input_channel_enable_q)
      && $stable(primary_fault_pin_mask_q) && !rd_valid_q)
    else $error("rejected command took effect");
  a_overtemp_off: assert property (overtemp |=> channel_active_q == BYTE_ZERO
      && !led_drive_on_q && secondary_fault_status_q[SEC_OT_SHDN]
      && secondary_fault_status_q[SEC_CREF_OPN]
      && secondary_fault_status_q[SEC_WREF_OPN])
    else $error("overtemperature shutdown incomplete");
  a_cref_open_flag: assert property (cref_open && !overtemp && !cref_short |=>
      secondary_fault_status_q[SEC_CREF_OPN] && channel_active_q == $past(input_channel_enable_q))
    else $error("current reference open handled wrongly");
  a_cref_short_off: assert property (cref_short[*2] |=>
      secondary_fault_status_q[SEC_CREF_SHT] && channel_active_q == BYTE_ZERO)
    else $error("current reference short did not disable inputs");
  a_wref_open_flag: assert property (wref_open || wb_detect_enable == BYTE_ZERO
      |=> secondary_fault_status_q[SEC_WREF_OPN])
    else $error("wire-break reference open not flagged");
  a_wref_short_flag: assert property (wref_short |=> secondary_fault_status_q[SEC_WREF_SHT])
    else $error("wire-break reference short not flagged");
  a_sec_clear_read: assert property (s_sec_read_quiet |=> secondary_fault_status_q == BYTE_ZERO
      && rd_valid_q && rd_data_q == $past(secondary_fault_status_q))
    else $error("secondary status not cleared by read");
  a_summary_sets: assert property (summary_live |=> primary_fault_status_q[PRIM_SUMMARY])
    else $error("summary bit missed an enabled source");
  a_summary_kept: assert property (rd_en && cmd_addr == ADDR_PRIMARY && summary_live
      |=> primary_fault_status_q[PRIM_SUMMARY])
    else $error("summary bit cleared while source enabled");
endmodule

// ==== tb/ifr_host_model.sv ====
/*
  Host-side model of the serial controller: issues one decoded register
  command per call on the parallel command port of the register bank.
  Assumes the bench supplies ref_clk and calls send from its main sequence.
*/
`timescale 1ns/1ps
module ifr_host_model (
  // clock
  input  wire logic ref_clk,
  // decoded command toward the register bank
  output logic       cmd_valid,
  output logic       cmd_clk_ok,
  output logic       cmd_write,
  output logic [6:0] cmd_addr,
  output logic [7:0] cmd_wdata
);
  // ----------------------------------------------------------------------
  // command driver
  // ----------------------------------------------------------------------
  // idle lines start at defined levels so nothing is unknown at time zero
  initial begin
    cmd_valid  = 1'b0;
    cmd_clk_ok = 1'b1;
    cmd_write  = 1'b0;
    cmd_addr   = 7'h00;
    cmd_wdata  = 8'h00;
  end

  // one frame per call; frame_ok is low only when a scenario breaks the count
  task automatic send(input logic wr, input logic [6:0] addr, input logic [7:0] data,
                      input logic frame_ok);
    @(posedge ref_clk);
    #1;
    cmd_valid  = 1'b1;
    cmd_clk_ok = frame_ok;
    cmd_write  = wr;
    cmd_addr   = addr;
    cmd_wdata  = data;
    @(posedge ref_clk);
    #1;
    // released fields show the inverse so stale values never look valid
    cmd_valid  = 1'b0;
    cmd_clk_ok = ~cmd_clk_ok;
    cmd_write  = ~cmd_write;
    cmd_addr   = ~cmd_addr;
    cmd_wdata  = ~cmd_wdata;
  endtask
endmodule

// ==== tb/test_input_fault_control_regs.sv ====
/*
  Self-checking bench for the input enable and fault reporting registers.
  Assumes the host model drives commands; the bench drives the status inputs.
*/
`timescale 1ns/1ps
module test_input_fault_control_regs;
  import ifr_pkg::*;
  logic       ref_clk, rst, cmd_valid, cmd_clk_ok, cmd_write, rd_valid_q;
  logic       led_drive_on_q, fault_n_q;
  logic [6:0] cmd_addr;
  logic [7:0] cmd_wdata, rd_data_q, channel_active_q, input_state_bits_q;
  logic [7:0] raw_inputs, wb_en, psrc, en, ex;
  logic [4:0] flt; // overtemp, cref open, cref short, wref open, wref short
  logic [7:0] exp_q[$];
  logic [31:0] rng;
  int         mismatches, samples_checked, i;

  // ----------------------------------------------------------------------
  // clock, design and host
  // ----------------------------------------------------------------------
  initial ref_clk = 1'b0;
  always #5 ref_clk = ~ref_clk;

  ifr_regs ifr_regs_i (.ref_clk(ref_clk), .rst(rst), .cmd_valid(cmd_valid),
    .cmd_clk_ok(cmd_clk_ok), .cmd_write(cmd_write), .cmd_addr(cmd_addr),
    .cmd_wdata(cmd_wdata), .rd_valid_q(rd_valid_q), .rd_data_q(rd_data_q),
    .raw_inputs(raw_inputs), .wb_detect_enable(wb_en), .overtemp(flt[4]),
    .cref_open(flt[3]), .cref_short(flt[2]), .wref_open(flt[1]), .wref_short(flt[0]),
    .crc_error(psrc[7]), .temp_alarm_low(psrc[3]), .temp_alarm_high(psrc[4]),
    .supply_low(psrc[2]), .supply_missing(psrc[1]), .wirebreak_any(psrc[0]),
    .channel_active_q(channel_active_q), .input_state_bits_q(input_state_bits_q),
    .led_drive_on_q(led_drive_on_q), .fault_n_q(fault_n_q));

  ifr_host_model ifr_host_model_i (.ref_clk(ref_clk), .cmd_valid(cmd_valid),
    .cmd_clk_ok(cmd_clk_ok), .cmd_write(cmd_write), .cmd_addr(cmd_addr),
    .cmd_wdata(cmd_wdata));

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  function automatic logic [7:0] rnd();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng[7:0];
  endfunction

  task automatic tally_and_finish();
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] expv);
    samples_checked++;
    if (seen !== expv) begin
      $display("mismatch at %0t: saw %h expected %h", $time, seen, expv);
      mismatches++;
    end
  endtask

  task automatic tick();
    @(posedge ref_clk);
    #1;
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    ifr_host_model_i.send(1'b1, a, d, 1'b1);
  endtask

  // the expected answer is noted before the read is issued
  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    ifr_host_model_i.send(1'b0, a, 8'h00, 1'b1);
  endtask

  // bounded wait for the fault pin; running out ends the run
  task automatic wait_pin(input logic v, input int n);
    int k;
    for (k = 0; k < n && fault_n_q !== v; k++) begin
      @(posedge ref_clk);
      #2;
    end
    samples_checked++;
    if (fault_n_q !== v) begin
      $display("mismatch at %0t: fault pin not %b", $time, v);
      mismatches++;
      tally_and_finish();
    end
  endtask

  // read answers are matched against the oldest note; an unasked answer fails
  always @(posedge ref_clk) begin
    #2;
    if (rd_valid_q === 1'b1) begin
      if (exp_q.size() == 0) begin
        $display("mismatch at %0t: unexpected read answer", $time);
        mismatches++;
      end else begin
        check(rd_data_q, exp_q.pop_front());
      end
    end
  end

  // watchdog against a hang anywhere in the sequence
  initial begin
    #300000;
    $display("mismatch at %0t: watchdog expired", $time);
    mismatches++;
    tally_and_finish();
  end

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    rst = 1'b1;
    raw_inputs = 8'h00;
    wb_en = 8'h00;
    psrc = 8'h00;
    flt = 5'h00;
    rng = 32'h48;
    mismatches = 0;
    samples_checked = 0;
    repeat (10) @(posedge ref_clk);
    #1;
    rst = 1'b0;
    wait_pin(1'b0, 3);
    rd(7'h1A, 8'hFF);
    rd(7'h1C, 8'h02);
    rd(7'h1C, 8'h02);
    rd(7'h1E, 8'h00);
    rd(7'h22, 8'h00);
    rd(7'h24, 8'hC0);
    wb_en = rnd() | 8'h01;
    tick();
    tick();
    rd(7'h1C, 8'h02);
    rd(7'h1C, 8'h00);
    // reserved bits, read-only and unmapped places
    wr(7'h1E, 8'hFF);
    rd(7'h1E, 8'h3F);
    wr(7'h1E, 8'h00);
    wr(7'h22, 8'h7F);
    rd(7'h22, 8'h00);
    wr(7'h1C, 8'hFF);
    rd(7'h1C, 8'h00);
    wr(7'h7F, 8'hA5);
    rd(7'h7F, 8'h00);
    // broken frames: a refused write and a refused read
    ifr_host_model_i.send(1'b1, 7'h1A, 8'h00, 1'b0);
    ifr_host_model_i.send(1'b0, 7'h1C, 8'h00, 1'b0);
    rd(7'h1A, 8'hFF);
    rd(7'h1C, 8'h20);
    rd(7'h1C, 8'h00);
    // random channel enables against random input levels
    for (i = 0; i < 4; i++) begin
      en = rnd();
      raw_inputs = rnd();
      wr(7'h1A, en);
      tick();
      check(channel_active_q, en);
      check(input_state_bits_q, raw_inputs & en);
    end
    rd(7'h1A, en);
    // each reference fault alone, then the latched flag read out once and read again as cleared
    for (i = 4; i >= 0; i--) begin
      flt = 5'h01 << i;
      tick();
      tick();
      ex = (i == 4 || i == 2) ? 8'h00 : en;
      check(channel_active_q, ex);
      check(input_state_bits_q, ex & raw_inputs);
      check({7'h00, led_drive_on_q}, {7'h00, i != 4});
      flt = 5'h00;
      tick();
      tick();
      rd(7'h1C, (i == 4) ? 8'h1A : (8'h01 << i));
      rd(7'h1C, 8'h00);
    end
    // live pin: each primary source with its mask on, then off
    wr(7'h04, 8'h00);
    wait_pin(1'b1, 4);
    // supply flags latched since reset are still set until the first read
    rd(7'h04, 8'h06);
    for (i = 0; i < 8; i++) begin
      if (i != 5 && i != 6) begin
        wr(7'h24, 8'h01 << i);
        psrc[i] = 1'b1;
        wait_pin(1'b0, 4);
        tick();
        psrc = 8'h00;
        wait_pin(1'b1, 4);
        wr(7'h24, 8'h00);
        psrc[i] = 1'b1;
        repeat (3) tick();
        check({7'h00, fault_n_q}, 8'h01);
        psrc = 8'h00;
        tick();
        rd(7'h04, (i >= 1 && i <= 4) ? (8'h01 << i) : 8'h00);
      end
    end
    // sticky pin fed by the secondary summary
    wr(7'h22, 8'h80);
    wr(7'h24, 8'h20);
    wr(7'h1E, 8'h01);
    flt = 5'h01;
    tick();
    flt = 5'h00;
    wait_pin(1'b0, 5);
    repeat (4) tick();
    rd(7'h04, 8'h20);
    tick();
    wait_pin(1'b0, 1);
    rd(7'h1C, 8'h01);
    rd(7'h04, 8'h20);
    wait_pin(1'b1, 5);
    rd(7'h04, 8'h00);
    repeat (4) tick();
    check(8'(exp_q.size()), 8'h00);
    tally_and_finish();
  end
endmodule
